// *** design/alu_pop_pkg.sv ***
// constants for the logical OR and stack pop execution block
// assumes a byte-wide register file reached by the core
package alu_pop_pkg;
    localparam logic [7:0] OPC_OR_RR     = 8'h42;
    localparam logic [7:0] OPC_OR_RIR    = 8'h43;
    localparam logic [7:0] OPC_OR_R_R    = 8'h44;
    localparam logic [7:0] OPC_OR_R_IR   = 8'h45;
    localparam logic [7:0] OPC_OR_R_IM   = 8'h46;
    localparam logic [7:0] OPC_POP_R     = 8'h50;
    localparam logic [7:0] OPC_POP_IR    = 8'h51;
    localparam int         POP_CYCLES    = 8;
    localparam int         OR_CYCLES     = 4;
    localparam logic [15:0] SP_RESET     = 16'h0000;
    localparam logic [7:0] FLAGS_RESET   = 8'h00;
    // flag bit positions in the flags register
    localparam int         FLAG_C_BIT    = 7;
    localparam int         FLAG_Z_BIT    = 6;
    localparam int         FLAG_S_BIT    = 5;
    localparam int         FLAG_V_BIT    = 4;
    localparam int         FLAG_D_BIT    = 3;
    localparam int         SIGN_BIT      = 7;
    typedef enum logic [1:0] {OP_NONE, OP_OR, OP_POP} op_kind_t;
endpackage

// *** design/rf_if.sv ***
// register file port carried between the sequencer and the datapath
// assumes one read and one write per cycle, combinational read data
`timescale 1ns/1ps
interface rf_if;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    logic       wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    modport core (output rd_addr, input rd_data, output wr_en, output wr_addr, output wr_data);
    modport file (input rd_addr, output rd_data, input wr_en, input wr_addr, input wr_data);
endinterface

// *** design/reg_file.sv ***
// 256-byte register file used by the execution block
// assumes writes land at the clock edge, reads are combinational
`timescale 1ns/1ps
module reg_file (
    input  wire logic clk,
    rf_if.file        rf,
    input  wire logic       ext_wr_en,
    input  wire logic [7:0] ext_wr_addr,
    input  wire logic [7:0] ext_wr_data,
    input  wire logic [7:0] ext_rd_addr,
    output logic      [7:0] ext_rd_data
);
    logic [7:0] mem [256];

    // core write wins over a loader write to the same cycle
    always_ff @(posedge clk) begin
        if (rf.wr_en) begin
            mem[rf.wr_addr] <= rf.wr_data;
        end else if (ext_wr_en) begin
            mem[ext_wr_addr] <= ext_wr_data;
        end
    end

    assign rf.rd_data  = mem[rf.rd_addr];
    assign ext_rd_data = mem[ext_rd_addr];
endmodule

// *** design/or_pop_exec.sv ***
// execution block for the logical OR and stack pop instructions
// assumes decode presents opcode and operand bytes with a one-cycle start pulse
`timescale 1ns/1ps
module or_pop_exec (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       start,
    input  wire logic [7:0] opcode,
    input  wire logic [7:0] dst_operand,
    input  wire logic [7:0] src_operand,
    output logic            busy,
    output logic            done,
    output logic            illegal_op,
    output logic [7:0]      flags,
    output logic [7:0]      stack_pointer_high,
    output logic [7:0]      stack_pointer_low,
    input  wire logic       load_en,
    input  wire logic [7:0] load_addr,
    input  wire logic [7:0] load_data,
    input  wire logic [7:0] peek_addr,
    output logic [7:0]      peek_data
);
    import alu_pop_pkg::*;

    typedef enum logic [2:0] {S_IDLE, S_RDPTR, S_RDSRC, S_RDDST, S_WRITE, S_WAIT} state_t;

    rf_if rf ();

    state_t     state_r;
    op_kind_t   kind_r;
    logic [7:0] opc_r;
    logic [7:0] dst_r;
    logic [7:0] src_r;
    logic [7:0] dst_addr_r;
    logic [7:0] src_val_r;
    logic [3:0] cnt_r;
    logic [7:0] flags_r;
    logic [15:0] stack_pointer_r;
    logic       done_r;
    logic       illegal_r;

    function automatic op_kind_t classify(input logic [7:0] opc);
        unique case (opc)
            OPC_OR_RR, OPC_OR_RIR, OPC_OR_R_R, OPC_OR_R_IR, OPC_OR_R_IM: classify = OP_OR;
            OPC_POP_R, OPC_POP_IR:                                       classify = OP_POP;
            default:                                                     classify = OP_NONE;
        endcase
    endfunction

    // working registers r0..r15 map to the first sixteen bytes
    function automatic logic [7:0] work_addr(input logic [7:0] v);
        work_addr = {4'h0, v[3:0]};
    endfunction

    function automatic logic src_indirect(input logic [7:0] opc);
        src_indirect = (opc == OPC_OR_RIR) || (opc == OPC_OR_R_IR);
    endfunction

    function automatic logic is_working(input logic [7:0] opc);
        is_working = (opc == OPC_OR_RR) || (opc == OPC_OR_RIR);
    endfunction

    // only the indirect-source OR forms finish straight out of the write stage; the other OR forms pass through the wait stage
    function automatic logic last_cycle(input op_kind_t k, input logic [3:0] c);
        last_cycle = (c >= 4'((k == OP_POP) ? POP_CYCLES : OR_CYCLES) - 4'h1);
    endfunction

    logic [7:0] or_result;
    assign or_result = rf.rd_data | src_val_r;

    // register file read address per state
    always_comb begin
        rf.rd_addr = 8'h00;
        unique case (state_r)
            S_RDPTR: rf.rd_addr = (kind_r == OP_POP) ? stack_pointer_r[7:0] : src_r;
            S_RDSRC: rf.rd_addr = src_val_r;
            S_RDDST: rf.rd_addr = dst_addr_r;
            default: rf.rd_addr = dst_addr_r;
        endcase
    end

    always_comb begin
        rf.wr_en   = 1'b0;
        rf.wr_addr = dst_addr_r;
        rf.wr_data = src_val_r;
        if (state_r == S_WRITE) begin
            rf.wr_en   = 1'b1;
            rf.wr_data = (kind_r == OP_OR) ? or_result : src_val_r;
        end
    end

    reg_file u_rf (
        .clk         (clk),
        .rf          (rf),
        .ext_wr_en   (load_en),
        .ext_wr_addr (load_addr),
        .ext_wr_data (load_data),
        .ext_rd_addr (peek_addr),
        .ext_rd_data (peek_data)
    );

    // sequencer
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r    <= S_IDLE;
            kind_r     <= OP_NONE;
            opc_r      <= 8'h00;
            dst_r      <= 8'h00;
            src_r      <= 8'h00;
            dst_addr_r <= 8'h00;
            src_val_r  <= 8'h00;
            cnt_r      <= 4'h0;
        end else begin
            cnt_r <= cnt_r + 4'h1;
            unique case (state_r)
                S_IDLE: begin
                    cnt_r <= 4'h1;
                    if (start && classify(opcode) != OP_NONE) begin
                        kind_r <= classify(opcode);
                        opc_r  <= opcode;
                        dst_r  <= is_working(opcode) ? work_addr(dst_operand) : dst_operand;
                        src_r  <= is_working(opcode) ? work_addr(src_operand) : src_operand;
                        state_r <= S_RDPTR;
                    end
                end
                S_RDPTR: begin
                    // immediate source needs no register read
                    src_val_r <= (opc_r == OPC_OR_R_IM) ? src_r : rf.rd_data;
                    if (kind_r == OP_POP && opc_r == OPC_POP_IR) begin
                        // pointer register is read next, from the destination field
                        dst_addr_r <= dst_r;
                        state_r    <= S_RDDST;
                    end else if (kind_r == OP_OR && src_indirect(opc_r)) begin
                        state_r <= S_RDSRC;
                    end else begin
                        // reads are combinational, so the write stage fetches the destination
                        dst_addr_r <= dst_r;
                        state_r    <= S_WRITE;
                    end
                end
                S_RDSRC: begin
                    src_val_r  <= rf.rd_data;
                    dst_addr_r <= dst_r;
                    state_r    <= S_WRITE;
                end
                S_RDDST: begin
                    dst_addr_r <= rf.rd_data; // indirect destination pointer
                    state_r    <= S_WRITE;
                end
                S_WRITE: begin
                    state_r <= last_cycle(kind_r, cnt_r) ? S_IDLE : S_WAIT;
                end
                S_WAIT: begin
                    if (last_cycle(kind_r, cnt_r)) begin
                        state_r <= S_IDLE;
                    end
                end
            endcase
        end
    end

    // stack pointer, incremented on the same edge that writes the destination
    always_ff @(posedge clk) begin
        if (rst) begin
            stack_pointer_r <= SP_RESET;
        end else if (state_r == S_WRITE && kind_r == OP_POP) begin
            stack_pointer_r <= stack_pointer_r + 16'h0001;
        end
    end

    // flags only change at the end of the OR write stage
    always_ff @(posedge clk) begin
        if (rst) begin
            flags_r <= FLAGS_RESET;
        end else if (state_r == S_WRITE && kind_r == OP_OR) begin
            flags_r[FLAG_Z_BIT] <= (or_result == 8'h00);
            flags_r[FLAG_S_BIT] <= or_result[SIGN_BIT];
            flags_r[FLAG_V_BIT] <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            done_r    <= 1'b0;
            illegal_r <= 1'b0;
        end else begin
            done_r    <= (state_r == S_WRITE || state_r == S_WAIT) &&
                         last_cycle(kind_r, cnt_r);
            illegal_r <= (state_r == S_IDLE) && start && (classify(opcode) == OP_NONE);
        end
    end

    assign busy               = (state_r != S_IDLE);
    assign done               = done_r;
    assign illegal_op         = illegal_r;
    assign flags              = flags_r;
    assign stack_pointer_high = stack_pointer_r[15:8];
    assign stack_pointer_low  = stack_pointer_r[7:0];

    a_pop_flags_kept: assert property (@(posedge clk) disable iff (rst)
        (kind_r == OP_POP && busy) |=> $stable(flags))
        else $error("flags changed during pop");
    a_pop_sp_inc: assert property (@(posedge clk) disable iff (rst)
        (state_r == S_WRITE && kind_r == OP_POP)
        |=> ({stack_pointer_high, stack_pointer_low} == $past(stack_pointer_r) + 16'h0001))
        else $error("stack pointer not incremented");
    a_pop_length: assert property (@(posedge clk) disable iff (rst)
        (state_r == S_IDLE && start && classify(opcode) == OP_POP) |-> ##8 done)
        else $error("pop not eight cycles");
    a_pop_write: assert property (@(posedge clk) disable iff (rst)
        (state_r == S_WRITE && kind_r == OP_POP) |-> (rf.wr_en && rf.wr_data == src_val_r))
        else $error("pop data not written");
    a_pop_read_addr: assert property (@(posedge clk) disable iff (rst)
        (state_r == S_RDPTR && kind_r == OP_POP) |-> (rf.rd_addr == stack_pointer_low))
        else $error("pop read not at pointer");
    a_or_result: assert property (@(posedge clk) disable iff (rst)
        (state_r == S_WRITE && kind_r == OP_OR) |-> rf.wr_data == (rf.rd_data | src_val_r))
        else $error("or result wrong");
    a_or_zero: assert property (@(posedge clk) disable iff (rst)
        (state_r == S_WRITE && kind_r == OP_OR)
        |=> flags[FLAG_Z_BIT] == ($past(or_result) == 8'h00))
        else $error("zero flag wrong");
    a_or_sign: assert property (@(posedge clk) disable iff (rst)
        (state_r == S_WRITE && kind_r == OP_OR) |=> flags[FLAG_S_BIT] == $past(or_result[7]))
        else $error("sign flag wrong");
    a_or_v_d: assert property (@(posedge clk) disable iff (rst)
        (state_r == S_WRITE && kind_r == OP_OR)
        |=> (!flags[FLAG_V_BIT] && flags[FLAG_D_BIT] == $past(flags[FLAG_D_BIT])))
        else $error("overflow or decimal flag wrong");
    a_sp_carry: assert property (@(posedge clk) disable iff (rst)
        (state_r == S_WRITE && kind_r == OP_POP && stack_pointer_low == 8'hFF)
        |=> (stack_pointer_low == 8'h00 &&
             stack_pointer_high == $past(stack_pointer_high) + 8'h01))
        else $error("pointer carry lost");
endmodule

// *** test/tb_or_pop_exec.sv ***
// self-checking bench for the OR and stack pop execution block
// assumes the register file starts unknown and the pointer resets to zero
`timescale 1ns/1ps
module tb_or_pop_exec;
    import alu_pop_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        start = 1'b0;
    logic [7:0]  opcode = 8'h00;
    logic [7:0]  dst_operand = 8'h00;
    logic [7:0]  src_operand = 8'h00;
    logic        busy, done, illegal_op;
    logic [7:0]  flags, stack_pointer_high, stack_pointer_low, peek_data;
    logic        load_en = 1'b0;
    logic [7:0]  load_addr = 8'h00;
    logic [7:0]  load_data = 8'h00;
    logic [7:0]  peek_addr = 8'h00;
    logic [7:0]  a, b, r, s, v, op, fprev, dfld;
    logic [15:0] sp_exp;
    int          err_total = 0;
    int          cmp_count = 0;
    int          k, extra;

    or_pop_exec dut_u (.clk(clk), .rst(rst), .start(start), .opcode(opcode),
        .dst_operand(dst_operand), .src_operand(src_operand), .busy(busy), .done(done),
        .illegal_op(illegal_op), .flags(flags), .stack_pointer_high(stack_pointer_high),
        .stack_pointer_low(stack_pointer_low), .load_en(load_en), .load_addr(load_addr),
        .load_data(load_data), .peek_addr(peek_addr), .peek_data(peek_data));

    always #2.5 clk = ~clk;

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic load(input logic [7:0] ad, input logic [7:0] d);
        load_en = 1'b1;
        load_addr = ad;
        load_data = d;
        @(posedge clk); #1;
        load_en = 1'b0;
    endtask

    task automatic peek(input logic [7:0] ad, output logic [7:0] d);
        peek_addr = ad;
        @(posedge clk); #1;
        d = peek_data;
    endtask

    // poke re-raises start mid-operation; busy must swallow it
    task automatic run_op(input logic [7:0] o, input logic [7:0] d, input logic [7:0] sr,
                          input int poke, output int n);
        opcode = o;
        dst_operand = d;
        src_operand = sr;
        start = 1'b1;
        @(posedge clk); #1;
        start = 1'b0;
        n = 1;
        while (done !== 1'b1 && n < 20) begin
            @(posedge clk); #1;
            n++;
            start = (n == poke);
        end
        start = 1'b0;
        chk("busy_at_done", busy, 1'b0);
    endtask

    function automatic logic [3:0] or_flags(input logic [7:0] p, input logic [7:0] res);
        return {res == 8'h00, res[SIGN_BIT], 1'b0, p[FLAG_D_BIT]};
    endfunction

    task automatic pop_chk(input logic [7:0] o, input logic [7:0] d, input int poke);
        fprev = flags;
        run_op(o, d, 8'h00, poke, k);
        sp_exp = sp_exp + 16'h0001;
        chk("pop_time", 16'(k), 16'(POP_CYCLES));
        chk("pop_sp", {stack_pointer_high, stack_pointer_low}, sp_exp);
        chk("pop_flags", flags, fprev);
    endtask

    initial begin
        #100000;
        err_total++;
        wrap_up();
    end

    initial begin
        void'($urandom(1));
        repeat (3) @(posedge clk);
        #1 rst = 1'b0;
        sp_exp = SP_RESET;
        chk("rst_flags", flags, FLAGS_RESET);
        chk("rst_sp", {stack_pointer_high, stack_pointer_low}, SP_RESET);
        for (int i = 0; i < 12; i++) begin
            a = (i == 1) ? 8'h80 : (i == 11) ? 8'h00 : 8'($urandom);
            b = (i == 1 || i == 11) ? 8'h00 : 8'($urandom);
            load(8'h00, a);
            load(8'h01, b);
            load(8'h02, 8'h01);
            // working-register forms must ignore the upper nibble of each field
            op = (i % 5 == 0) ? OPC_OR_R_R : (i % 5 == 1) ? OPC_OR_R_IR
               : (i % 5 == 2) ? OPC_OR_R_IM : (i % 5 == 3) ? OPC_OR_RR : OPC_OR_RIR;
            s = (i % 5 == 0) ? 8'h01 : (i % 5 == 1) ? 8'h02 : (i % 5 == 2) ? b
              : (i % 5 == 3) ? 8'hE1 : 8'hE2;
            dfld = (i % 5 >= 3) ? 8'hE0 : 8'h00;
            fprev = flags;
            run_op(op, dfld, s, 0, k);
            chk("or_time", 16'(k), 16'(OR_CYCLES));
            peek(8'h00, r);
            chk("or_dst", r, a | b);
            peek(8'h01, r);
            chk("or_src", r, b);
            chk("or_zsvd", {flags[FLAG_Z_BIT], flags[FLAG_S_BIT], flags[FLAG_V_BIT],
                flags[FLAG_D_BIT]}, or_flags(fprev, a | b));
        end
        v = 8'($urandom);
        load(sp_exp[7:0], v);
        pop_chk(OPC_POP_R, 8'h20, 0);
        peek(8'h20, r);
        chk("pop_reg", r, v);
        v = 8'($urandom);
        load(sp_exp[7:0], v);
        load(8'h21, 8'h22);
        pop_chk(OPC_POP_IR, 8'h21, 3);
        peek(8'h22, r);
        chk("pop_ind", r, v);
        peek(8'h21, r);
        chk("pop_ptr_reg", r, 8'h22);
        extra = 0;
        repeat (10) begin
            @(posedge clk); #1;
            if (done === 1'b1) extra++;
        end
        chk("no_second_op", extra, 0);
        chk("one_increment", {stack_pointer_high, stack_pointer_low}, sp_exp);
        fprev = flags;
        opcode = 8'hFF;
        start = 1'b1;
        @(posedge clk); #1;
        start = 1'b0;
        chk("illegal_pulse", illegal_op, 1'b1);
        @(posedge clk); #1;
        chk("illegal_end", illegal_op, 1'b0);
        chk("illegal_sp", {stack_pointer_high, stack_pointer_low}, sp_exp);
        chk("illegal_flags", flags, fprev);
        while (sp_exp != 16'h0100) pop_chk(OPC_POP_R, 8'hF0, 0);
        chk("sp_high", stack_pointer_high, 8'h01);
        chk("sp_low", stack_pointer_low, 8'h00);
        wrap_up();
    end
endmodule
